// file: core/asct_pkg.sv
package asct_pkg;
   // Bus geometry
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int LANES  = 2;

   // Clock period in picoseconds (40 MHz)
   localparam int CLK_PS = 25000;

   // Timing figures in picoseconds, fast grade then slow grade
   localparam int ADDR_ACCESS_DELAY_F_PS   = 45000;
   localparam int ADDR_ACCESS_DELAY_S_PS   = 55000;
   localparam int SELECT_ACCESS_DELAY_F_PS = 45000;
   localparam int SELECT_ACCESS_DELAY_S_PS = 55000;
   localparam int OUTPUT_DRIVE_DELAY_F_PS  = 22000;
   localparam int OUTPUT_DRIVE_DELAY_S_PS  = 25000;
   localparam int LANE_ACCESS_DELAY_F_PS   = 45000;
   localparam int LANE_ACCESS_DELAY_S_PS   = 55000;
   localparam int ADDR_SETUP_TO_END_F_PS   = 35000;
   localparam int ADDR_SETUP_TO_END_S_PS   = 40000;
   localparam int LANE_ACTIVE_TO_END_F_PS  = 35000;
   localparam int LANE_ACTIVE_TO_END_S_PS  = 40000;
   localparam int WDATA_SETUP_PS           = 25000;
   localparam int STROBE_LOW_TO_FLOAT_F_PS = 18000;
   localparam int STROBE_LOW_TO_FLOAT_S_PS = 20000;
   localparam int ADDR_SETUP_TO_START_PS   = 0;
   localparam int ADDR_HOLD_AFTER_END_PS   = 0;
   localparam int WDATA_HOLD_PS            = 0;
   localparam int ADDR_CHANGE_HOLD_PS      = 10000;

   // Round a least time up, never below one cycle
   function automatic int asct_cyc_min(input int ps);
      int c;
      c = (ps + CLK_PS - 1) / CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction : asct_cyc_min

   // Read sample point: longest of address, select, lane and output access
   localparam int RD_F_PS = ADDR_ACCESS_DELAY_F_PS;
   localparam int RD_S_PS = ADDR_ACCESS_DELAY_S_PS;
   // Plus one cycle so the edge that samples lies strictly after the delay
   localparam int RD_CYC_F = asct_cyc_min(RD_F_PS) + 1;
   localparam int RD_CYC_S = asct_cyc_min(RD_S_PS) + 1;

   // Write pulse: max of addr/lane setup to end and float plus data setup
   localparam int WR_F_PS = (ADDR_SETUP_TO_END_F_PS > STROBE_LOW_TO_FLOAT_F_PS + WDATA_SETUP_PS)
                            ? ADDR_SETUP_TO_END_F_PS : STROBE_LOW_TO_FLOAT_F_PS + WDATA_SETUP_PS;
   localparam int WR_S_PS = (ADDR_SETUP_TO_END_S_PS > STROBE_LOW_TO_FLOAT_S_PS + WDATA_SETUP_PS)
                            ? ADDR_SETUP_TO_END_S_PS : STROBE_LOW_TO_FLOAT_S_PS + WDATA_SETUP_PS;
   localparam int WR_CYC_F = asct_cyc_min(WR_F_PS);
   localparam int WR_CYC_S = asct_cyc_min(WR_S_PS);

   // Counter width
   localparam int CNT_W = 4;

   typedef enum logic [1:0] {
      ASCT_IDLE,
      ASCT_READ,
      ASCT_WRITE,
      ASCT_RECOVER
   } asct_state_type;
endpackage : asct_pkg

// file: core/asct_lane_io.sv
`timescale 1ns/1ps
`default_nettype none
// Per-lane data pin driver and read capture
module asct_lane_io
   import asct_pkg::*;
#(
   parameter int LANE_W = 8
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // Control
   input  wire logic              drive_en,
   input  wire logic              capture,
   input  wire logic [LANE_W-1:0] wr_byte,
   // Pins
   input  wire logic [LANE_W-1:0] pin_in,
   output logic      [LANE_W-1:0] pin_out,
   output logic                   pin_oe,
   // Captured byte
   output logic      [LANE_W-1:0] rd_byte
);
   typedef struct packed {
      logic [LANE_W-1:0] dout;
      logic              oe;
      logic [LANE_W-1:0] din;
   } asct_lane_type;

   asct_lane_type st_ff, nxt_st;

   // Output enable follows the owner's drive request from a flop
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.oe   = drive_en;
      nxt_st.dout = wr_byte;
      if (capture) begin
         nxt_st.din = pin_in;
      end
   end

   // One register stage; reset leaves the lane undriven
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pin_out = st_ff.dout;
   assign pin_oe  = st_ff.oe;
   assign rd_byte = st_ff.din;
endmodule : asct_lane_io
`default_nettype wire

// file: core/asct_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// One access at a time: a read or a write is taken only from idle, and the
// memory is left deselected in between, so it drops into standby on its own.
// Writes end on the strobe alone; address, data, selects and lanes stay put
// for one more cycle, so every zero hold figure is met by a whole period.
// Reads sample at a fixed count worked out for the slowest access path of
// the grade; a quicker path gains nothing, but no answer from the memory is
// needed, and it has none.
// Read to read spacing is the sample count plus two cycles; a write is
// followed by its next take after the pulse count plus two.
// The error flag of a read is captured with the data at the same edge.
// Limitation: no page mode and no write ended by the selects or lanes.
module asct_ctrl
   import asct_pkg::*;
#(
   parameter bit SLOW_GRADE = 1'b0
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // User request
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   input  wire logic [LANES-1:0]  req_lane_en,
   // User answer
   output logic                   rsp_valid,
   output logic      [DATA_W-1:0] rsp_rdata,
   output logic                   rsp_err,
   // Memory pins
   output logic      [ADDR_W-1:0] mem_addr,
   output logic                   select_low_n,
   output logic                   select_high,
   output logic                   write_strobe_n,
   output logic                   output_en_n,
   output logic                   upper_lane_sel_n,
   output logic                   lower_lane_sel_n,
   input  wire logic [DATA_W-1:0] mem_data_in,
   output logic      [DATA_W-1:0] mem_data_out,
   output logic      [LANES-1:0]  mem_data_oe,
   input  wire logic              mem_err_in
);
   // Lane width; each lane has its own select and data driver
   localparam int LANE_W = DATA_W / LANES;

   // Grade chosen at build time, figures rounded up to whole cycles
   // Reads wait one cycle past the rounded delay so the sample edge lies beyond it
   localparam logic [CNT_W-1:0] RD_CYC = CNT_W'(SLOW_GRADE ? RD_CYC_S : RD_CYC_F);
   localparam logic [CNT_W-1:0] WR_CYC = CNT_W'(SLOW_GRADE ? WR_CYC_S : WR_CYC_F);

   // Whole controller state, registered as one record
   typedef struct packed {
      asct_state_type    state;
      logic [CNT_W-1:0]  cnt;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [LANES-1:0]  lane;
      logic              sel;
      logic              we;
      logic              oe;
      logic              drive;
      logic              rsp;
      logic              err;
   } asct_ctrl_type;

   // Registered state, its next value and the one-cycle read capture strobe
   asct_ctrl_type st_ff, nxt_st;
   logic          capture;

   // Sequencer: one access at a time, always ends deselected
   always_comb begin
      nxt_st     = st_ff;
      // Defaults: the answer pulse lasts one cycle, no capture
      nxt_st.rsp = 1'b0;
      capture    = 1'b0;
      case (st_ff.state)
         // Idle: drop selects and lanes so the memory sits in standby
         ASCT_IDLE: begin
            nxt_st.sel   = 1'b0;
            nxt_st.lane  = '0;
            nxt_st.we    = 1'b0;
            nxt_st.oe    = 1'b0;
            nxt_st.drive = 1'b0;
            // A request with no lane enabled is ignored and never taken
            if (req_valid && (req_lane_en != '0)) begin
               // Address, selects and lanes rise together; strobe is low from the
               // same edge, zero setup is allowed
               nxt_st.addr  = req_addr;
               nxt_st.wdata = req_wdata;
               nxt_st.lane  = req_lane_en;
               nxt_st.sel   = 1'b1;
               nxt_st.cnt   = '0;
               if (req_write) begin
                  // Data drivers come on with the strobe while output enable stays high
                  nxt_st.we    = 1'b1;
                  nxt_st.drive = 1'b1;
                  nxt_st.state = ASCT_WRITE;
               end else begin
                  nxt_st.oe    = 1'b1;
                  nxt_st.state = ASCT_READ;
               end
            end
         end

         // Read: output enable low, count up to the sample edge
         ASCT_READ: begin
            // Count starts from zero at the take edge
            nxt_st.cnt = st_ff.cnt + 1'b1;
            // Longest access delay has passed before this sample edge
            if (st_ff.cnt == RD_CYC - 1'b1) begin
               capture     = 1'b1;
               nxt_st.err  = mem_err_in;
               nxt_st.rsp  = 1'b1;
               // Release output enable, selects and lanes at the sample edge
               nxt_st.oe   = 1'b0;
               nxt_st.sel  = 1'b0;
               nxt_st.lane = '0;
               nxt_st.state = ASCT_RECOVER;
            end
         end

         // Write: strobe low for the rounded pulse length
         ASCT_WRITE: begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
            // Strobe alone ends the write; address, data and lanes stay put at
            // that edge so hold figures of zero are met with a full cycle
            if (st_ff.cnt == WR_CYC - 1'b1) begin
               nxt_st.we  = 1'b0;
               nxt_st.rsp = 1'b1;
               nxt_st.state = ASCT_RECOVER;
            end
         end

         // Recover: address and data still held for one cycle
         ASCT_RECOVER: begin
            // One idle cycle: data drivers, selects and lanes released after write end; address stays
            nxt_st.drive = 1'b0;
            nxt_st.sel   = 1'b0;
            nxt_st.lane  = '0;
            nxt_st.state = ASCT_IDLE;
         end

         // Unused state code falls back to idle
         default: begin
            nxt_st.state = ASCT_IDLE;
         end
      endcase
   end

   // State register; reset leaves every pin inactive and the data bus undriven
   // Reset is synchronous, so a request may follow in the cycle after release
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_ff <= '{state: ASCT_IDLE, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Data pins per lane; drive only while writing, never while reading
   // Enables come from the next state, so the pins switch at the same edge
   // as strobe and selects and never overlap the memory's own drive
   // Capture is shared; disabled lanes take in floating pins, masked by the user
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         asct_lane_io #(.LANE_W(LANE_W)) u_lane (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .drive_en(nxt_st.drive && nxt_st.lane[g] && !nxt_st.oe),
            .capture (capture),
            .wr_byte (nxt_st.wdata[g*LANE_W +: LANE_W]),
            .pin_in  (mem_data_in[g*LANE_W +: LANE_W]),
            .pin_out (mem_data_out[g*LANE_W +: LANE_W]),
            .pin_oe  (mem_data_oe[g]),
            .rd_byte (rsp_rdata[g*LANE_W +: LANE_W])
         );
      end
   endgenerate

   // Address stands from the take until the next request
   assign mem_addr         = st_ff.addr;

   // Pin outputs from flops; select pair encodes one effective select
   assign select_low_n     = ~st_ff.sel;
   assign select_high      = st_ff.sel;

   // Strobe, output enable and lane selects are all active low
   assign write_strobe_n   = ~st_ff.we;
   assign output_en_n      = ~st_ff.oe;
   assign lower_lane_sel_n = ~st_ff.lane[0];
   assign upper_lane_sel_n = ~st_ff.lane[1];

   // User side: ready only while idle, answer and flag from flops
   assign req_ready        = (st_ff.state == ASCT_IDLE);
   assign rsp_valid        = st_ff.rsp;
   assign rsp_err          = st_ff.err;
endmodule : asct_ctrl
`default_nettype wire

// file: verif/asct_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Pin timing checks beside the controller
module asct_checker
   import asct_pkg::*;
#(parameter bit SLOW_GRADE = 1'b0) (
   // Clock, reset and user side
   input wire logic              clk_sys,
   input wire logic              rst_n,
   input wire logic              req_ready,
   input wire logic              rsp_valid,
   // Memory pins
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              select_low_n,
   input wire logic              select_high,
   input wire logic              write_strobe_n,
   input wire logic              output_en_n,
   input wire logic              upper_lane_sel_n,
   input wire logic              lower_lane_sel_n,
   input wire logic [LANES-1:0]  mem_data_oe
);
   localparam int RD_N = SLOW_GRADE ? RD_CYC_S : RD_CYC_F;
   logic [CNT_W-1:0] oe_cnt_ff;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Length of the output enable pulse, which is the read access window
   always_ff @(posedge clk_sys) oe_cnt_ff <= (!rst_n || output_en_n) ? 4'h0 : oe_cnt_ff + 4'h1;
   property p_wr_pulse;
      $fell(write_strobe_n) |-> ##1 !write_strobe_n ##1 (write_strobe_n && rsp_valid);
   endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse length");
   property p_wr_addr; !write_strobe_n |=> $stable(mem_addr); endproperty
   a_wr_addr: assert property (p_wr_addr) else $error("write address moved");
   property p_wr_start; $fell(write_strobe_n) |-> !select_low_n && select_high
      && mem_data_oe == ~{upper_lane_sel_n, lower_lane_sel_n} && mem_data_oe != 2'h0; endproperty
   a_wr_start: assert property (p_wr_start) else $error("write start");
   property p_wr_end; $rose(write_strobe_n) |-> $stable(mem_data_oe) && !select_low_n; endproperty
   a_wr_end: assert property (p_wr_end) else $error("write end");
   property p_rd_pins; !output_en_n |-> write_strobe_n && mem_data_oe == 2'h0; endproperty
   a_rd_pins: assert property (p_rd_pins) else $error("read pins");
   property p_idle; req_ready |-> select_low_n && !select_high && output_en_n; endproperty
   a_idle: assert property (p_idle) else $error("idle not deselected");
   property p_rd_sample; $rose(output_en_n) |-> rsp_valid && oe_cnt_ff == RD_N; endproperty
   a_rd_sample: assert property (p_rd_sample) else $error("read sample point");
   property p_rsp; rsp_valid |=> !rsp_valid; endproperty
   a_rsp: assert property (p_rsp) else $error("answer pulse");
   // Main transfer kinds
   cover property ($fell(write_strobe_n));
   cover property ($rose(output_en_n));
   cover property ($fell(write_strobe_n) && mem_data_oe == 2'h3);
endmodule : asct_checker
bind asct_ctrl asct_checker #(.SLOW_GRADE(SLOW_GRADE)) chk_u (.*);
`default_nettype wire

// file: verif/asct_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural memory at the far side of the pins
module asct_mem_model
   import asct_pkg::*;
#(parameter int ACC_NS = 45) (
   // Control pins
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              select_low_n,
   input wire logic              select_high,
   input wire logic              write_strobe_n,
   input wire logic              output_en_n,
   input wire logic              upper_lane_sel_n,
   input wire logic              lower_lane_sel_n,
   // Data pins, resolved here from both drivers
   input wire logic [DATA_W-1:0] mem_data_out,
   input wire logic [LANES-1:0]  mem_data_oe,
   output logic     [DATA_W-1:0] mem_data_in,
   output logic                  mem_err_in
);
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [DATA_W-1:0] q = 16'h0000, junk = 16'h5a5a, lm, om, dm;
   logic              sel, rd;
   realtime           t_chg = 0.0;
   // Effective select, read condition and per-bit lane and drive masks
   assign sel = !select_low_n && select_high;
   assign rd = sel && !output_en_n && write_strobe_n;
   assign lm = {{8{!upper_lane_sel_n}}, {8{!lower_lane_sel_n}}};
   assign om = {{8{mem_data_oe[1]}}, {8{mem_data_oe[0]}}};
   assign dm = rd ? lm & ~om : 16'h0000;
   // Lines nobody drives flip every step, so a stale value never passes
   assign mem_data_in = (om & mem_data_out) | (dm & q) | (~om & ~dm & junk);
   assign mem_err_in = rd ? ^q : junk[0];
   // Any new address, select or enable restarts the access time
   always @(mem_addr, sel, output_en_n, lm) t_chg = $realtime;
   // One worst-case delay serves all access paths
   always begin
      junk = ~junk;
      if ($realtime - t_chg >= ACC_NS) begin
         q = mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
      end else if ($realtime - t_chg >= 10.0) begin
         q = junk;
      end
      #1;
   end
   // The strobe edge ends a write; lanes still enabled are stored
   always @(posedge write_strobe_n) begin
      if (sel) mem[mem_addr] = (mem_data_in & lm)
         | (~lm & (mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000));
   end
endmodule : asct_mem_model
`default_nettype wire

// file: verif/tb_async_sram_cycle_timing.sv
`timescale 1ns/1ps
`default_nettype none
// Random traffic through the controller into a memory model
module tb_async_sram_cycle_timing
   import asct_pkg::*;
   ;
   logic clk_sys = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   logic req_ready, rsp_valid, rsp_err, select_low_n, select_high, write_strobe_n, output_en_n;
   logic upper_lane_sel_n, lower_lane_sel_n, mem_err_in;
   logic [ADDR_W-1:0] req_addr = 20'h00000, mem_addr;
   logic [DATA_W-1:0] req_wdata = 16'h0000, rsp_rdata, mem_data_in, mem_data_out, old, m;
   logic [LANES-1:0]  req_lane_en = 2'h1, mem_data_oe;
   logic [31:0]       rs = 32'hffe39984;
   logic [33:0]       notes [$], nt;
   logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
   int                failures = 0, n_tests = 0, n;
   asct_ctrl #(.SLOW_GRADE(1'b0)) dut_u (.*);
   asct_mem_model #(.ACC_NS(45)) mem_u (.*);
   // 40 MHz system clock
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Xorshift source of random stimulus
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction : xs
   task automatic check(input string s, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask : check
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   // Each answer retires the oldest note; only reads carry data
   always @(posedge clk_sys) begin
      if (rsp_valid === 1'b1) begin
         check("answer expected", 16'(notes.size() != 0), 16'h0001);
         if (notes.size() != 0) nt = notes.pop_front();
         if (nt[33] === 1'b0) begin
            check("read data", rsp_rdata & nt[31:16], nt[15:0]);
            check("error flag", {15'h0000, rsp_err}, {15'h0000, nt[32]});
         end
      end
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      // Back to back, few addresses, so reads meet earlier partial writes
      for (int k = 0; k < 60; k++) begin
         rs = xs(rs);
         req_valid <= 1'b1;
         req_write <= rs[0];
         req_addr <= {rs[6], 16'h0000, rs[3:1]};
         req_wdata <= rs[31:16];
         req_lane_en <= (rs[5:4] == 2'h0) ? 2'h3 : rs[5:4];
         n = 0;
         do begin @(posedge clk_sys); n++; end while (req_ready !== 1'b1 && n < 20);
         if (n == 20) failures++;
         m = {{8{req_lane_en[1]}}, {8{req_lane_en[0]}}};
         old = shadow.exists(req_addr) ? shadow[req_addr] : 16'h0000;
         if (req_write) shadow[req_addr] = (old & ~m) | (req_wdata & m);
         notes.push_back({req_write, ^old, m, old & m});
      end
      $display("test traffic done");
      // A request with no lane enabled must be ignored
      req_lane_en <= 2'h0;
      repeat (8) @(posedge clk_sys);
      check("idle on empty lanes", {15'h0000, req_ready}, 16'h0001);
      check("answers outstanding", 16'(notes.size()), 16'h0000);
      $display("test refusal done");
      test_done();
   end
   // Traffic needs some 300 cycles; a hang is cut at 2000
   initial begin
      #50000;
      failures++;
      test_done();
   end
endmodule : tb_async_sram_cycle_timing
`default_nettype wire
